//--- bse_beam_state_evaluator.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module bse_beam_state_evaluator
#(
    parameter int MS_CYCLES = bse_pkg::MS_CYC
)
(
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // AHB-Lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Beam states and trigger pins
    input  wire logic [31:0] i_beam_free,
    input  wire logic        i_trig_in,
    output logic             o_trig_out,
    output logic             o_meas_done,
    output logic      [31:0] o_area
);
    import bse_pkg::*;

    bse_state_t st_r;
    bse_state_t st_nxt;
    logic [31:0] beff;
    logic        us_tick;
    logic        trig_rise;
    logic        own_pulse;

    function automatic logic [31:0] range_mask(input logic [5:0] lo, input logic [5:0] hi);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < NB; i++)
        begin
            m[i] = (6'(i) >= lo) && (6'(i) <= hi);
        end
        return m;
    endfunction

    function automatic logic [5:0] first_one(input logic [31:0] v);
        logic [5:0] f;
        f = '0;
        for (int i = NB - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                f = 6'(i + 1);
            end
        end
        return f;
    endfunction

    function automatic logic [5:0] last_one(input logic [31:0] v);
        logic [5:0] f;
        f = '0;
        for (int i = 0; i < NB; i++)
        begin
            if (v[i])
            begin
                f = 6'(i + 1);
            end
        end
        return f;
    endfunction

    function automatic logic [5:0] popcnt(input logic [31:0] v);
        logic [5:0] c;
        c = '0;
        for (int i = 0; i < NB; i++)
        begin
            c = c + 6'(v[i]);
        end
        return c;
    endfunction

    // Free beams lying strictly inside the span of interrupted ones
    function automatic logic [31:0] inner_free(input logic [31:0] b, input logic [31:0] k);
        logic [5:0] lo;
        logic [5:0] hi;
        lo = first_one(b);
        hi = last_one(b);
        if (lo == 6'h00)
        begin
            return '0;
        end
        return ~b & ~k & range_mask(lo - 6'h01, hi - 6'h01);
    endfunction

    assign beff      = (st_r.bcnt != 6'h00) ? st_r.bmask : '0;
    assign us_tick   = (st_r.us_div == 7'(US_CYC - 1));
    assign trig_rise = i_trig_in && !st_r.trig_prev;
    assign own_pulse = !st_r.ext && st_r.master && us_tick
                       && (st_r.per_cnt == 16'h0000);

    always_comb
    begin
        logic        start;
        logic        bitv;
        logic [7:0]  thr;
        logic [31:0] clr;
        logic [5:0]  res [6];
        logic [31:0] rd;
        logic [31:0] mir;
        start = 1'b0;
        bitv  = 1'b0;
        thr   = '0;
        clr   = '0;
        rd    = '0;
        mir   = {<<{i_beam_free}};
        for (int i = 0; i < 6; i++)
        begin
            res[i] = '0;
        end
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        st_nxt.trig_prev = i_trig_in;
        st_nxt.us_div = us_tick ? '0 : st_r.us_div + 7'h01;
        st_nxt.ms_div = (st_r.ms_div == 17'(MS_CYCLES - 1)) ? '0 : st_r.ms_div + 17'h00001;
        if (st_r.ms_div == 17'(MS_CYCLES - 1) && st_r.hold_cnt != 16'h0000)
        begin
            st_nxt.hold_cnt = st_r.hold_cnt - 16'h0001;
        end
        // Master pulse lasts one microsecond; the period restarts as the pulse begins
        if (us_tick)
        begin
            st_nxt.trig_out = own_pulse;
            st_nxt.per_cnt  = (st_r.per_cnt == 16'h0000) ? st_r.period - 16'h0001
                                                         : st_r.per_cnt - 16'h0001;
        end
        // Period count parks at zero until master is enabled, so a new period
        // takes effect at once instead of after the old count runs out
        if (st_r.ext || !st_r.master)
        begin
            st_nxt.trig_out = 1'b0;
            st_nxt.per_cnt  = '0;
        end
        start = (!st_r.ext && st_r.master) ? own_pulse : trig_rise;
        case (st_r.fsm)
            ST_IDLE:
            begin
                // Triggers while a measurement runs are ignored
                if (start)
                begin
                    st_nxt.fsm     = ST_DELAY;
                    st_nxt.dly_cnt = st_r.offset;
                end
            end
            ST_DELAY:
            begin
                if (st_r.dly_cnt == 16'h0000)
                begin
                    st_nxt.raw = st_r.rev ? mir : i_beam_free;
                    st_nxt.wk  = ~st_nxt.raw & ~beff;
                    st_nxt.idx = '0;
                    st_nxt.run_len = '0;
                    st_nxt.fsm = ST_SCAN1;
                end
                else if (us_tick)
                begin
                    st_nxt.dly_cnt = st_r.dly_cnt - 16'h0001;
                end
            end
            ST_SCAN1, ST_SCAN2:
            begin
                // Serial scan keeps area small; one beam per clock
                thr  = (st_r.fsm == ST_SCAN1 && st_r.inv) ? 8'h01 : st_r.smooth;
                bitv = (st_r.idx != 6'(NB)) && st_r.wk[st_r.idx[4:0]];
                if (bitv)
                begin
                    if (st_r.run_len == 8'h00)
                    begin
                        st_nxt.run_st = st_r.idx[4:0];
                    end
                    if (st_r.run_len != 8'hff)
                    begin
                        st_nxt.run_len = st_r.run_len + 8'h01;
                    end
                end
                else
                begin
                    if (st_r.run_len != 8'h00 && st_r.run_len < thr)
                    begin
                        clr = range_mask({1'b0, st_r.run_st}, st_r.idx - 6'h01);
                        st_nxt.wk = st_r.wk & ~clr;
                    end
                    st_nxt.run_len = '0;
                end
                st_nxt.idx = st_r.idx + 6'h01;
                if (st_r.idx == 6'(NB))
                begin
                    st_nxt.idx = '0;
                    if (st_r.fsm == ST_SCAN1)
                    begin
                        st_nxt.blk = st_nxt.wk;
                        st_nxt.wk  = inner_free(st_nxt.wk, beff);
                        st_nxt.fsm = st_r.inv ? ST_SCAN2 : ST_PUB;
                    end
                    else
                    begin
                        // Short inner gaps are not reported as free
                        st_nxt.blk = st_r.blk | (inner_free(st_r.blk, beff) & ~st_nxt.wk);
                        st_nxt.fsm = ST_PUB;
                    end
                end
            end
            ST_PUB:
            begin
                clr    = ~st_r.blk & ~beff;
                res[0] = first_one(st_r.blk);
                res[1] = last_one(st_r.blk);
                res[2] = first_one(clr);
                res[3] = last_one(clr);
                res[4] = popcnt(st_r.blk);
                res[5] = popcnt(clr);
                st_nxt.area = st_r.blk;
                for (int i = 0; i < 6; i++)
                begin
                    if (st_r.hold_cnt == 16'h0000)
                    begin
                        st_nxt.rmax[i] = res[i];
                        st_nxt.rmin[i] = res[i];
                    end
                    else
                    begin
                        st_nxt.rmax[i] = (res[i] > st_r.rmax[i]) ? res[i] : st_r.rmax[i];
                        st_nxt.rmin[i] = (res[i] < st_r.rmin[i]) ? res[i] : st_r.rmin[i];
                    end
                end
                if (st_r.hold_cnt == 16'h0000)
                begin
                    st_nxt.hold_cnt = st_r.hold;
                end
                if (st_r.teach)
                begin
                    if (st_r.bcnt != 6'h00)
                    begin
                        st_nxt.bmask = ~st_r.raw;
                    end
                    st_nxt.teach = 1'b0;
                end
                st_nxt.done = 1'b1;
                st_nxt.fsm  = ST_IDLE;
            end
            default:
            begin
                st_nxt.fsm = ST_IDLE;
            end
        endcase
        // Bus write lands after the engine so a teach request is never lost
        if (st_r.wr_pend)
        begin
            case (st_r.addr)
                A_CTRL:
                begin
                    st_nxt.ext    = i_hwdata[CTRL_EXT];
                    st_nxt.master = i_hwdata[CTRL_MASTER];
                    st_nxt.rev    = i_hwdata[CTRL_REV];
                    st_nxt.inv    = i_hwdata[CTRL_INV];
                    if (i_hwdata[CTRL_TEACH])
                    begin
                        st_nxt.teach = 1'b1;
                    end
                end
                A_SMOOTH: st_nxt.smooth = (i_hwdata[7:0] == 8'h00) ? 8'h01 : i_hwdata[7:0];
                A_HOLD:   st_nxt.hold = i_hwdata[15:0];
                A_OFFSET: st_nxt.offset = i_hwdata[15:0];
                A_PERIOD: st_nxt.period = (i_hwdata[15:0] == 16'h0000) ? 16'h0001 : i_hwdata[15:0];
                A_BCNT:   st_nxt.bcnt = i_hwdata[5:0];
                A_BMASK:  st_nxt.bmask = i_hwdata;
                default:  st_nxt.bcnt = st_nxt.bcnt;
            endcase
        end
        case (st_r.addr)
            A_CTRL:   rd = {27'h0, st_r.teach, st_r.inv, st_r.rev, st_r.master, st_r.ext};
            A_SMOOTH: rd = {24'h0, st_r.smooth};
            A_HOLD:   rd = {16'h0, st_r.hold};
            A_OFFSET: rd = {16'h0, st_r.offset};
            A_PERIOD: rd = {16'h0, st_r.period};
            A_BCNT:   rd = {26'h0, st_r.bcnt};
            A_BMASK:  rd = st_r.bmask;
            A_STATUS: rd = {28'h0, st_r.trig_out, st_r.trig_prev, st_r.teach,
                            st_r.fsm != ST_IDLE};
            A_AREA:   rd = st_r.area;
            A_RAW:    rd = st_r.raw;
            default:  rd = '0;
        endcase
        for (int i = 0; i < 6; i++)
        begin
            if (st_r.addr == A_RES0 + 8'(4 * i))
            begin
                rd = '0;
                rd[RES_MAX_LSB +: 6] = st_r.rmax[i];
                rd[5:0] = st_r.rmin[i];
            end
        end
        // Reads take one wait state so a write just before is seen
        st_nxt.hready = 1'b1;
        if (st_r.rd_pend)
        begin
            st_nxt.hrdata = rd;
        end
        st_nxt.wr_pend = i_hsel && i_htrans[1] && i_hready && i_hwrite;
        st_nxt.rd_pend = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
        if (i_hsel && i_htrans[1] && i_hready)
        begin
            st_nxt.addr = {i_haddr[7:2], 2'b00};
            st_nxt.hready = i_hwrite;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            st_r        <= '0;
            st_r.fsm    <= ST_IDLE;
            st_r.hready <= 1'b1;
            st_r.smooth <= SMOOTH_RST;
            st_r.period <= PERIOD_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_hrdata    = st_r.hrdata;
    assign o_hreadyout = st_r.hready;
    assign o_hresp     = 1'b0;
    assign o_trig_out  = st_r.trig_out;
    assign o_meas_done = st_r.done;
    assign o_area      = st_r.area;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    sequence seq_scan;
        (st_r.fsm == ST_SCAN1) ##32 (st_r.fsm == ST_SCAN1) ##1 (st_r.fsm != ST_SCAN1);
    endsequence
    sequence seq_rd_wait;
        !st_r.hready ##1 st_r.hready;
    endsequence

    AST_SMOOTH_RANGE: assert property (st_r.smooth != 8'h00)
        else $error("smoothing value reached zero");
    AST_TRIG_MASTER: assert property ($rose(st_r.trig_out) |-> $past(!st_r.ext && st_r.master))
        else $error("trigger out pulsed while not internal master");
    AST_START_OFFSET: assert property ((st_r.fsm == ST_IDLE && trig_rise && !(!st_r.ext && st_r.master))
        |=> (st_r.fsm == ST_DELAY && st_r.dly_cnt == $past(st_r.offset)))
        else $error("trigger did not start offset delay");
    AST_SCAN_LEN: assert property ($rose(st_r.fsm == ST_SCAN1) |-> seq_scan)
        else $error("beam scan length wrong");
    AST_FIRST_LAST: assert property ((st_r.fsm == ST_PUB && st_r.hold_cnt == 16'h0000)
        |=> (st_r.rmin[0] == first_one($past(st_r.blk)) && st_r.rmax[1] == last_one($past(st_r.blk))))
        else $error("first or last interrupted beam wrong");
    AST_HOLD_MAX: assert property ((st_r.fsm == ST_PUB && st_r.hold_cnt != 16'h0000)
        |=> (st_r.rmax[4] >= $past(st_r.rmax[4]) && st_r.rmin[5] <= $past(st_r.rmin[5])))
        else $error("held extreme value lost");
    AST_BLANK_EXCL: assert property ((st_r.fsm == ST_PUB) |-> ((st_r.blk & beff) == '0))
        else $error("blanked beam counted");
    AST_TEACH_MAP: assert property ((st_r.fsm == ST_PUB && st_r.teach && st_r.bcnt != 6'h00
        && !st_r.wr_pend) |=> (st_r.bmask == ~$past(st_r.raw) && !st_r.teach))
        else $error("teach did not map interrupted beams");
    AST_SMOOTH_ONE: assert property ((st_r.fsm == ST_PUB && st_r.smooth == 8'h01 && !st_r.inv)
        |-> (st_r.blk == (~st_r.raw & ~beff)))
        else $error("smoothing one dropped a beam");
    AST_RD_WAIT: assert property ((i_hsel && i_htrans[1] && i_hready && !i_hwrite) |=> seq_rd_wait)
        else $error("read wait state wrong");
endmodule

//--- bse_pkg.sv
// Functional notes
// - Report first and last interrupted and free beam numbers each cycle.
// - Report per-beam area status bits and trigger input/output levels.
// - With a hold time set, keep stored results for that hold time.
// - During hold, keep minima and maxima of all six results.
// - Blanked beams never count; beam numbers stay unchanged.
// - Teach with blanking enabled replaces blanking mask by interrupted beams.
// - Teach with no interrupted beam leaves an empty blanking mask.
// - Zero blanking areas disables blanking; software should teach again.
// - Interrupted beam counts only inside a run reaching the smoothing value.
// - Smoothing one lets every interrupted beam count.
// - Smoothing two drops isolated single interrupted beams.
// - Smoothing three reports nothing unless three adjacent beams are interrupted.
// - Smoothing accepts 1 to 255; zero is raised to one.
// - Inverted smoothing reports inner free runs only when long enough.
// - A control bit selects internal or external trigger.
// - Measurement starts after this curtain's own offset from the trigger.
// - Internal master generates trigger pulses on its own, continuously.
// - Slaves start measuring from the master pulse on their input.
// - A free beam is a one in the beam state bit.
// - Reversed counting direction mirrors all first and last results.
package bse_pkg;
    localparam int NB = 32;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_SMOOTH = 8'h04;
    localparam logic [7:0] A_HOLD = 8'h08;
    localparam logic [7:0] A_OFFSET = 8'h0c;
    localparam logic [7:0] A_PERIOD = 8'h10;
    localparam logic [7:0] A_BCNT = 8'h14;
    localparam logic [7:0] A_BMASK = 8'h18;
    localparam logic [7:0] A_STATUS = 8'h1c;
    localparam logic [7:0] A_AREA = 8'h20;
    localparam logic [7:0] A_RES0 = 8'h24;
    localparam logic [7:0] A_RAW = 8'h3c;
    localparam int CTRL_EXT = 0;
    localparam int CTRL_MASTER = 1;
    localparam int CTRL_REV = 2;
    localparam int CTRL_INV = 3;
    localparam int CTRL_TEACH = 4;
    localparam int RES_MAX_LSB = 16;
    localparam logic [7:0] SMOOTH_RST = 8'h01;
    localparam logic [15:0] PERIOD_RST = 16'h03e8;
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int MS_NS = 1000000;
    localparam int US_CYC = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
    typedef enum {ST_IDLE, ST_DELAY, ST_SCAN1, ST_SCAN2, ST_PUB} bse_fsm_t;
    typedef struct packed {
        bse_fsm_t         fsm;
        logic             hready;
        logic [31:0]      hrdata;
        logic             wr_pend;
        logic             rd_pend;
        logic [7:0]       addr;
        logic             ext;
        logic             master;
        logic             rev;
        logic             inv;
        logic             teach;
        logic [7:0]       smooth;
        logic [15:0]      hold;
        logic [15:0]      offset;
        logic [15:0]      period;
        logic [5:0]       bcnt;
        logic [31:0]      bmask;
        logic             trig_prev;
        logic             trig_out;
        logic [6:0]       us_div;
        logic [16:0]      ms_div;
        logic [15:0]      per_cnt;
        logic [15:0]      dly_cnt;
        logic [15:0]      hold_cnt;
        logic [31:0]      raw;
        logic [31:0]      wk;
        logic [31:0]      blk;
        logic [5:0]       idx;
        logic [7:0]       run_len;
        logic [4:0]       run_st;
        logic [31:0]      area;
        logic [5:0][5:0]  rmax;
        logic [5:0][5:0]  rmin;
        logic             done;
    } bse_state_t;
endpackage

//--- bse_trig_partner.sv
`timescale 1ns/10ps
module bse_trig_partner
#(
    parameter int PULSE_CYC  = 4,
    parameter int MASTER_PER = 300
)
(
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    // Bench control
    input  wire logic i_fire,
    input  wire logic i_free_run,
    // Trigger line to the curtain
    output logic      o_trig
);
    int width_r;
    int per_r;

    // Controller pulse on request, or an upstream master curtain running free
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            width_r <= 0;
            per_r   <= 0;
        end
        else
        begin
            per_r <= (per_r >= MASTER_PER - 1) ? 0 : per_r + 1;
            // Several cycles wide so the edge cannot be missed
            if (i_fire || (i_free_run && per_r == 0))
                width_r <= PULSE_CYC;
            else if (width_r != 0)
                width_r <= width_r - 1;
        end
    end

    assign o_trig = (width_r != 0);
endmodule

//--- beam_state_evaluator_bench.sv
`timescale 1ns/10ps
module beam_state_evaluator_bench;
    import bse_pkg::*;
    logic        clk, rst, hsel, hwrite, fire, free_run, trig;
    logic        hreadyout, hresp, trig_out, meas_done;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, beam_free, area, v;
    int          err_total, compares, n, m;
    localparam logic [31:0] PAT1 = ~32'h0000_0f30;
    localparam logic [31:0] PAT2 = ~32'h00f8_0e32;
    localparam logic [7:0]  RA[8] = '{A_CTRL, A_SMOOTH, A_HOLD, A_OFFSET, A_PERIOD,
                                      A_BCNT, A_BMASK, 8'hfc};
    localparam logic [31:0] RV[8] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h3e8, 32'h0, 32'h0, 32'h0};
    localparam logic [31:0] SP[6] = '{PAT2, PAT2, PAT2, PAT2, ~32'h0000_0033, PAT2};
    localparam logic [31:0] SM[6] = '{32'h1, 32'h2, 32'h3, 32'h5, 32'h3, 32'hff};

    bse_beam_state_evaluator #(.MS_CYCLES(10)) uut
    (
        .i_sys_clk   (clk),
        .i_rst       (rst),
        .i_hsel      (hsel),
        .i_haddr     (haddr),
        .i_htrans    (htrans),
        .i_hwrite    (hwrite),
        .i_hsize     (hsize),
        .i_hwdata    (hwdata),
        .i_hready    (hreadyout),
        .o_hrdata    (hrdata),
        .o_hreadyout (hreadyout),
        .o_hresp     (hresp),
        .i_beam_free (beam_free),
        .i_trig_in   (trig),
        .o_trig_out  (trig_out),
        .o_meas_done (meas_done),
        .o_area      (area)
    );

    bse_trig_partner partner
    (
        .i_sys_clk  (clk),
        .i_rst      (rst),
        .i_fire     (fire),
        .i_free_run (free_run),
        .o_trig     (trig)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_of_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic pick(input int w);
        return (w == 0) ? hreadyout : ((w == 1) ? meas_done : trig_out);
    endfunction

    // Every wait is bounded so a stuck design ends the run
    task automatic wait_val(input int w, input logic lvl, input int lim, output int c);
        c = 0;
        do
        begin
            @(posedge clk);
            c++;
        end while (pick(w) !== lvl && c < lim);
        if (pick(w) !== lvl)
        begin
            err_total++;
            $display("MISMATCH t=%0t wait ran out", $time);
            end_of_test();
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int c;
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        wait_val(0, 1'b1, 50, c);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? d : 32'h0;
        wait_val(0, 1'b1, 50, c);
        v = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        check(v, e);
    endtask

    task automatic measure(input logic [31:0] pat, output int c);
        beam_free <= pat;
        fire      <= 1'b1;
        @(posedge clk);
        fire      <= 1'b0;
        wait_val(1, 1'b1, 3000, c);
    endtask

    // Expected results: blanked beams drop out, short blocked runs turn free
    function automatic logic [35:0] ref_eval(input logic [31:0] fr, input logic [31:0] bl,
                                             input int sm);
        logic [31:0] blk;
        logic [31:0] keep;
        logic [5:0]  f1, l1, f0, l0, n1, n0;
        int          run;
        blk  = ~fr & ~bl;
        keep = 32'h0;
        run  = 0;
        {f1, l1, f0, l0, n1, n0} = 36'h0;
        for (int i = 0; i <= 32; i++)
        begin
            if (i < 32 && blk[i % 32])
                run++;
            else
            begin
                if (run >= sm)
                    for (int j = i - run; j < i; j++)
                        keep[j] = 1'b1;
                run = 0;
            end
        end
        for (int i = 0; i < 32; i++)
        begin
            if (keep[i])
            begin
                f1 = (f1 == 6'h0) ? 6'(i + 1) : f1;
                l1 = 6'(i + 1);
                n1 = n1 + 6'h1;
            end
            else if (!bl[i])
            begin
                f0 = (f0 == 6'h0) ? 6'(i + 1) : f0;
                l0 = 6'(i + 1);
                n0 = n0 + 6'h1;
            end
        end
        return {f1, l1, f0, l0, n1, n0};
    endfunction

    task automatic chk_res(input logic [35:0] a, input logic [35:0] b);
        logic [5:0] x, y;
        for (int k = 0; k < 6; k++)
        begin
            x = a[35 - 6 * k -: 6];
            y = b[35 - 6 * k -: 6];
            rd_chk(A_RES0 + 8'(4 * k), {10'h0, (x > y) ? x : y, 10'h0, (x < y) ? x : y});
        end
    endtask

    initial
    begin
        rst = 1'b1;
        {hsel, hwrite, fire, free_run, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        beam_free = 32'hffff_ffff;
        err_total = 0;
        compares = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 8; i++)
            rd_chk(RA[i], RV[i]);
        rd_chk(A_STATUS, 32'h0);
        wr(8'hfc, 32'hffff_ffff);
        rd_chk(8'hfc, 32'h0);
        check({31'h0, hresp}, 32'h0);
        wr(A_SMOOTH, 32'h0);
        rd_chk(A_SMOOTH, 32'h1);
        wr(A_CTRL, 32'h1);
        measure(PAT1, n);
        chk_res(ref_eval(PAT1, 32'h0, 1), ref_eval(PAT1, 32'h0, 1));
        check(area, ~PAT1);
        rd_chk(A_AREA, ~PAT1);
        rd_chk(A_RAW, PAT1);
        for (int i = 0; i < 6; i++)
        begin
            wr(A_SMOOTH, SM[i]);
            measure(SP[i], n);
            chk_res(ref_eval(SP[i], 0, SM[i]), ref_eval(SP[i], 0, SM[i]));
        end
        wr(A_SMOOTH, 32'h1);
        wr(A_BCNT, 32'h1);
        wr(A_BMASK, 32'h30);
        measure(PAT1, n);
        chk_res(ref_eval(PAT1, 32'h30, 1), ref_eval(PAT1, 32'h30, 1));
        wr(A_BCNT, 32'h0);
        measure(PAT1, n);
        chk_res(ref_eval(PAT1, 32'h0, 1), ref_eval(PAT1, 32'h0, 1));
        wr(A_BCNT, 32'h1);
        wr(A_CTRL, 32'h11);
        measure(PAT1, n);
        rd_chk(A_BMASK, ~PAT1);
        rd_chk(A_CTRL, 32'h1);
        measure(PAT1, n);
        chk_res(ref_eval(PAT1, ~PAT1, 1), ref_eval(PAT1, ~PAT1, 1));
        wr(A_CTRL, 32'h11);
        measure(32'hffff_ffff, n);
        rd_chk(A_BMASK, 32'h0);
        wr(A_BCNT, 32'h0);
        wr(A_CTRL, 32'h5);
        measure(PAT1, n);
        v = {<<{PAT1}};
        chk_res(ref_eval(v, 0, 1), ref_eval(v, 0, 1));
        wr(A_CTRL, 32'h9);
        wr(A_SMOOTH, 32'h8);
        measure(~32'h603, n);
        chk_res(ref_eval(~32'h7ff, 0, 1), ref_eval(~32'h7ff, 0, 1));
        wr(A_SMOOTH, 32'h7);
        measure(~32'h603, n);
        chk_res(ref_eval(~32'h603, 0, 1), ref_eval(~32'h603, 0, 1));
        wr(A_CTRL, 32'h1);
        wr(A_SMOOTH, 32'h1);
        wr(A_HOLD, 32'h64);
        measure(PAT1, n);
        measure(~32'h0c, n);
        chk_res(ref_eval(PAT1, 0, 1), ref_eval(~32'h0c, 0, 1));
        wr(A_HOLD, 32'h0);
        measure(PAT1, n);
        wr(A_OFFSET, 32'h2);
        measure(PAT1, m);
        check(32'(m - n > 100 && m - n < 203), 32'h1);
        wr(A_OFFSET, 32'h0);
        wr(A_CTRL, 32'h0);
        free_run <= 1'b1;
        wait_val(1, 1'b1, 1000, n);
        wait_val(1, 1'b1, 1000, n);
        check({31'h0, trig_out}, 32'h0);
        free_run <= 1'b0;
        wr(A_PERIOD, 32'h2);
        wr(A_CTRL, 32'h2);
        wait_val(2, 1'b1, 400, n);
        wait_val(2, 1'b0, 200, n);
        check(32'(n), 32'd100);
        wait_val(2, 1'b1, 400, m);
        check(32'(n + m), 32'd200);
        wait_val(1, 1'b1, 400, n);
        end_of_test();
    end
endmodule
